// >>> hdl/ddos_top.sv
// design: dual dac output sequencer with wishbone registers
//
// Register access over Wishbone and the register addresses are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module ddos_top #(
	parameter int CAL_CYC = ddos_pkg::CAL_CYC
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                ce_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                dma_valid_i,
	input  wire ddos_pkg::ddos_dma_t dma_i,
	output logic      [1:0]          dma_req_o,
	input  wire logic                ttl_sync_i,
	input  wire logic                lvds_sync_i,
	output logic                     ttl_sync_o,
	output logic                     lvds_sync_o,
	output logic      [15:0]         dac0_o,
	output logic      [15:0]         dac1_o,
	output logic      [1:0]          dac_ld_o,
	output logic                     cal_busy_o,
	output logic                     irq_o
);
	localparam int MG = ddos_pkg::MIN_GAP;

	// ==========================================
	// state
	ddos_pkg::ddos_ctrl_t  ctrl_q;
	ddos_pkg::ddos_ctrl_t  ctrl_d;
	ddos_pkg::ddos_burst_t bst_q;
	logic [11:0] rate_q [2];
	logic [15:0] div_q  [2];
	logic [11:0] acc_q  [2];
	logic [15:0] dcnt_q [2];
	logic [6:0]  gap_q  [2];
	logic [14:0] wp_q   [2];
	logic [14:0] rp_q   [2];
	logic [15:0] cnt_q  [2];
	logic [15:0] dac_q  [2];
	logic [16:0] mem_q  [2][ddos_pkg::FDEPTH];
	logic [1:0]  itick_q;
	logic [1:0]  eof_q;
	logic [26:0] cal_q;
	logic        cal_busy_q;
	logic        sync_prev_q;
	logic        seq_q;

	// ==========================================
	// combinational
	logic [31:0] rdata;
	logic [31:0] wm;
	logic        req;
	logic        wr;
	logic        cmd_w;
	logic        sw_clk;
	logic        sw_trig;
	logic        cal_go;
	logic        clr;
	logic        sync_in;
	logic        ext_edge;
	logic        trig;
	logic        go;
	logic [15:0] depth_n;
	logic [14:0] amask;
	logic [12:0] sum     [2];
	logic [16:0] rd_word [2];
	logic [16:0] wdat    [2];
	logic [1:0]  bus_push;
	logic [1:0]  push;
	logic [1:0]  pop;
	logic [1:0]  raw;
	logic [1:0]  fin;
	logic [1:0]  tick_g;
	logic [1:0]  eof_set;

	function automatic logic [31:0] lane_merge(
		input logic [31:0] o,
		input logic [31:0] n,
		input logic [3:0]  s
	);
		logic [31:0] r;
		for (int i = 0; i < 4; i++)
			r[i*8 +: 8] = s[i] ? n[i*8 +: 8] : o[i*8 +: 8];
		return r;
	endfunction

	function automatic logic [11:0] clamp_rate(input logic [11:0] r);
		if (r < ddos_pkg::RATE_MIN)
			return ddos_pkg::RATE_MIN;
		if (r > ddos_pkg::RATE_MAX)
			return ddos_pkg::RATE_MAX;
		return r;
	endfunction

	function automatic logic [14:0] nxt(
		input logic [14:0] p,
		input logic [14:0] m
	);
		return (p + 15'h0001) & m;
	endfunction

	function automatic logic [15:0] fmt(
		input logic [15:0] d,
		input logic        twos
	);
		return twos ? {~d[15], d[14:0]} : d;
	endfunction

	// ==========================================
	// bus decode
	assign req     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	assign wr      = req & wb_we_i;
	assign wm      = lane_merge(rdata, wb_dat_i, wb_sel_i);
	assign cmd_w   = wr & (wb_adr_i == ddos_pkg::OFS_CMD);
	assign sw_clk  = cmd_w & wm[ddos_pkg::CMD_SWCLK];
	assign sw_trig = cmd_w & wm[ddos_pkg::CMD_TRIG];
	assign cal_go  = cmd_w & wm[ddos_pkg::CMD_CAL] & ~cal_busy_q;
	assign clr     = cmd_w & wm[ddos_pkg::CMD_CLR];
	assign depth_n = ddos_pkg::DEPTH_MIN << ctrl_q.depth;
	assign amask   = depth_n[14:0] - 15'h0001;

	always_comb
	begin
		rdata = 32'h0000_0000;
		case (wb_adr_i)
			ddos_pkg::OFS_CTRL:  rdata = {16'h0000, ctrl_q};
			ddos_pkg::OFS_RATE0: rdata = {20'h00000, rate_q[0]};
			ddos_pkg::OFS_RATE1: rdata = {20'h00000, rate_q[1]};
			ddos_pkg::OFS_DIV0:  rdata = {16'h0000, div_q[0]};
			ddos_pkg::OFS_DIV1:  rdata = {16'h0000, div_q[1]};
			ddos_pkg::OFS_STAT:  rdata = {23'h000000, bst_q,
				cal_busy_q, eof_q,
				cnt_q[1] == depth_n, cnt_q[0] == depth_n,
				cnt_q[1] == 16'h0000, cnt_q[0] == 16'h0000};
			ddos_pkg::OFS_LEVEL: rdata = {cnt_q[1], cnt_q[0]};
			default:             rdata = 32'h0000_0000;
		endcase
	end

	always_comb
	begin
		ctrl_d      = ddos_pkg::ddos_ctrl_t'(wm[15:0]);
		ctrl_d.rsvd = 2'b00;
		if (ctrl_d.depth > ddos_pkg::DCODE_MAX)
			ctrl_d.depth = ddos_pkg::DCODE_MAX;
	end

	// ==========================================
	// wishbone slave: ack one cycle after the strobe
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else if (ce_i)
		begin
			wb_ack_o <= req;
			if (req)
				wb_dat_o <= rdata;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctrl_q <= ddos_pkg::ddos_ctrl_t'(ddos_pkg::CTRL_RST);
			for (int c = 0; c < 2; c++)
			begin
				rate_q[c] <= ddos_pkg::RATE_RST;
				div_q[c]  <= ddos_pkg::DIV_RST;
			end
		end
		else if (ce_i && wr)
		begin
			case (wb_adr_i)
				ddos_pkg::OFS_CTRL:  ctrl_q <= ctrl_d;
				ddos_pkg::OFS_RATE0: rate_q[0] <= clamp_rate(wm[11:0]);
				ddos_pkg::OFS_RATE1: rate_q[1] <= clamp_rate(wm[11:0]);
				ddos_pkg::OFS_DIV0:  div_q[0] <= wm[15:0];
				ddos_pkg::OFS_DIV1:  div_q[1] <= wm[15:0];
				default:             ;
			endcase
		end
	end

	// ==========================================
	// rate generators and dividers
	always_comb
	begin
		for (int c = 0; c < 2; c++)
			sum[c] = {1'b0, acc_q[c]} + {1'b0, rate_q[c]};
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			itick_q <= 2'b00;
			for (int c = 0; c < 2; c++)
			begin
				acc_q[c]  <= 12'h000;
				dcnt_q[c] <= 16'h0000;
			end
		end
		else if (ce_i)
		begin
			for (int c = 0; c < 2; c++)
			begin
				acc_q[c]   <= sum[c][11:0];
				itick_q[c] <= 1'b0;
				if (sum[c][12])
				begin
					if (dcnt_q[c] == div_q[c])
					begin
						dcnt_q[c]  <= 16'h0000;
						itick_q[c] <= 1'b1;
					end
					else
						dcnt_q[c] <= dcnt_q[c] + 16'h0001;
				end
			end
		end
	end

	// ==========================================
	// clock selection and pacing
	// the sync input is one line: as a trigger it cannot also be a clock
	assign sync_in  = ctrl_q.lvds ? lvds_sync_i : ttl_sync_i;
	assign ext_edge = sync_in & ~sync_prev_q;
	assign trig     = sw_trig | (ctrl_q.burst_en & ext_edge);
	assign go       = (~ctrl_q.burst_en | (bst_q == ddos_pkg::ST_RUN))
		& ~cal_busy_q;

	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			case (ctrl_q.src)
				ddos_pkg::SRC_INT: raw[c] = (ctrl_q.sync_clk
					| ctrl_q.simul) ? itick_q[0] : itick_q[c];
				ddos_pkg::SRC_EXT: raw[c] = ext_edge & ~ctrl_q.burst_en;
				ddos_pkg::SRC_SW:  raw[c] = sw_clk;
				default:           raw[c] = 1'b0;
			endcase
		end
		fin[0] = raw[0];
		if (ctrl_q.simul)
			fin[1] = raw[0];
		else if (ctrl_q.sync_clk)
			fin[1] = seq_q;
		else
			fin[1] = raw[1];
		// ticks inside the gap are dropped, keeping each channel at or below 400k
		tick_g[0] = fin[0] & go & (gap_q[0] == 7'h00);
		if (ctrl_q.simul)
			tick_g[1] = tick_g[0];
		else
			tick_g[1] = fin[1] & go & (gap_q[1] == 7'h00);
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sync_prev_q <= 1'b0;
			seq_q       <= 1'b0;
			gap_q[0]    <= 7'h00;
			gap_q[1]    <= 7'h00;
		end
		else if (ce_i)
		begin
			sync_prev_q <= sync_in;
			seq_q       <= raw[0];
			for (int c = 0; c < 2; c++)
			begin
				if (tick_g[c])
					gap_q[c] <= 7'(MG - 1);
				else if (gap_q[c] != 7'h00)
					gap_q[c] <= gap_q[c] - 7'h01;
			end
		end
	end

	// ==========================================
	// burst control
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			bst_q <= ddos_pkg::ST_IDLE;
		else if (ce_i)
		begin
			case (bst_q)
				ddos_pkg::ST_IDLE:
					if (ctrl_q.burst_en)
						bst_q <= ddos_pkg::ST_ARM;
				ddos_pkg::ST_ARM:
					if (!ctrl_q.burst_en)
						bst_q <= ddos_pkg::ST_IDLE;
					else if (trig)
						bst_q <= ddos_pkg::ST_RUN;
				ddos_pkg::ST_RUN:
					if (!ctrl_q.burst_en)
						bst_q <= ddos_pkg::ST_IDLE;
					else if (eof_set[0])
						bst_q <= ddos_pkg::ST_ARM;
				default:
					bst_q <= ddos_pkg::ST_IDLE;
			endcase
		end
	end

	// ==========================================
	// buffers
	always_comb
	begin
		for (int c = 0; c < 2; c++)
		begin
			rd_word[c]  = mem_q[c][rp_q[c]];
			bus_push[c] = wr & (wb_adr_i == (c == 0 ?
				ddos_pkg::OFS_DATA0 : ddos_pkg::OFS_DATA1));
			wdat[c] = bus_push[c] ? wm[16:0] : dma_i.data;
			push[c] = (bus_push[c] | (dma_valid_i
				& (dma_i.chan == c[0])))
				& (cnt_q[c] < depth_n) & ~clr;
			pop[c]     = tick_g[c] & (cnt_q[c] != 16'h0000);
			eof_set[c] = pop[c] & rd_word[c][16];
		end
	end

	// data storage carries no reset; pointers alone define contents
	always_ff @(posedge clk_i)
	begin
		if (ce_i)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (push[c])
					mem_q[c][wp_q[c]] <= wdat[c];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i || (ce_i && clr))
		begin
			for (int c = 0; c < 2; c++)
			begin
				wp_q[c]  <= 15'h0000;
				rp_q[c]  <= 15'h0000;
				cnt_q[c] <= 16'h0000;
			end
		end
		else if (ce_i)
		begin
			for (int c = 0; c < 2; c++)
			begin
				if (push[c])
					wp_q[c] <= nxt(wp_q[c], amask);
				if (pop[c] && ctrl_q.circ)
				begin
					if (nxt(rp_q[c], amask) == wp_q[c])
						rp_q[c] <= (wp_q[c] - cnt_q[c][14:0])
							& amask;
					else
						rp_q[c] <= nxt(rp_q[c], amask);
				end
				else if (pop[c])
					rp_q[c] <= nxt(rp_q[c], amask);
				cnt_q[c] <= cnt_q[c] + {15'h0000, push[c]}
					- {15'h0000, pop[c] & ~ctrl_q.circ};
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dma_req_o <= 2'b00;
		else if (ce_i)
		begin
			// two-entry margin covers a word already in flight
			for (int c = 0; c < 2; c++)
				dma_req_o[c] <= ctrl_q.dma_en & ((17'(cnt_q[c])
					+ 17'h00002) < 17'(depth_n));
		end
	end

	// ==========================================
	// converter outputs, calibration, sync out
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dac_q[0] <= ddos_pkg::MIDSCALE;
			dac_q[1] <= ddos_pkg::MIDSCALE;
			dac_ld_o <= 2'b11;
		end
		else if (ce_i)
		begin
			for (int c = 0; c < 2; c++)
			begin
				dac_ld_o[c] <= cal_go | pop[c];
				if (cal_go)
					dac_q[c] <= ddos_pkg::MIDSCALE;
				else if (pop[c])
					dac_q[c] <= fmt(rd_word[c][15:0],
						ctrl_q.twos);
			end
		end
	end
	assign dac0_o = dac_q[0];
	assign dac1_o = dac_q[1];

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cal_q      <= 27'h0000000;
			cal_busy_q <= 1'b0;
		end
		else if (ce_i)
		begin
			if (cal_go)
			begin
				cal_q      <= 27'(CAL_CYC);
				cal_busy_q <= 1'b1;
			end
			else if (cal_q != 27'h0000000)
			begin
				cal_q      <= cal_q - 27'h0000001;
				cal_busy_q <= (cal_q != 27'h0000001);
			end
		end
	end
	assign cal_busy_o = cal_busy_q;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ttl_sync_o  <= 1'b0;
			lvds_sync_o <= 1'b0;
		end
		else if (ce_i)
		begin
			ttl_sync_o  <= (ctrl_q.trig_out ? trig : tick_g[0])
				& ~ctrl_q.lvds;
			lvds_sync_o <= (ctrl_q.trig_out ? trig : tick_g[0])
				& ctrl_q.lvds;
		end
	end

	// set wins over a write-one clear in the same cycle
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			eof_q <= 2'b00;
			irq_o <= 1'b0;
		end
		else if (ce_i)
		begin
			eof_q <= eof_set | (eof_q & ~({2{wr && wb_adr_i ==
				ddos_pkg::OFS_STAT}} & wm[ddos_pkg::ST_EOF +: 2]));
			irq_o <= |eof_q;
		end
	end

	// ==========================================
	// assertions
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	a_mid_reset: assert property (
		$past(rst_i) |-> dac_q[0] == ddos_pkg::MIDSCALE
		&& dac_q[1] == ddos_pkg::MIDSCALE)
		else $error("outputs not at midscale after reset");
	a_div_tick: assert property (
		ce_i && sum[0][12] && dcnt_q[0] == div_q[0]
		|=> itick_q[0] && dcnt_q[0] == 16'h0000)
		else $error("divider terminal count missed");
	a_seq_share: assert property (
		ce_i && ctrl_q.sync_clk && !ctrl_q.simul
		&& ctrl_q.src == ddos_pkg::SRC_INT && itick_q[0]
		|=> fin[1])
		else $error("shared clock not passed to channel 1");
	a_rate_span: assert property (
		rate_q[1] >= ddos_pkg::RATE_MIN
		&& rate_q[1] <= ddos_pkg::RATE_MAX)
		else $error("rate word outside span");
	a_gap_block: assert property (
		ce_i && tick_g[0] |=> !tick_g[0] [*8])
		else $error("channel updated inside minimum gap");
	a_gap_load: assert property (
		ce_i && tick_g[1] |=> gap_q[1] == 7'(MG - 1))
		else $error("gap counter not loaded");
	a_sync_clk: assert property (
		ce_i && !ctrl_q.trig_out && tick_g[0]
		|=> ttl_sync_o || lvds_sync_o)
		else $error("sample clock not driven out");
	a_sync_lvl: assert property (
		!(ttl_sync_o && lvds_sync_o))
		else $error("both sync output levels driven");
	a_burst_go: assert property (
		ce_i && bst_q == ddos_pkg::ST_ARM && ctrl_q.burst_en && trig
		|=> bst_q == ddos_pkg::ST_RUN)
		else $error("trigger did not start burst");
	a_simul_upd: assert property (
		ctrl_q.simul |-> tick_g[1] == tick_g[0])
		else $error("simultaneous update split");
	a_depth_cap: assert property (
		cnt_q[0] <= depth_n && cnt_q[1] <= depth_n)
		else $error("buffer level above active depth");
	a_circ_keep: assert property (
		ce_i && ctrl_q.circ && pop[0] && !push[0] && !clr
		|=> $stable(cnt_q[0]))
		else $error("circular buffer consumed data");
	a_twos_fmt: assert property (
		ce_i && pop[0] && !cal_go |=> dac_q[0][15]
		== ($past(rd_word[0][15]) ^ $past(ctrl_q.twos)))
		else $error("sample format wrong");
	a_push_lvl: assert property (
		ce_i && push[0] && !pop[0] && !clr
		|=> cnt_q[0] == $past(cnt_q[0]) + 16'h0001)
		else $error("write did not enter buffer");
	a_eof_flag: assert property (
		ce_i && pop[0] && rd_word[0][16] |=> eof_q[0])
		else $error("frame end not flagged");
	a_irq_line: assert property (
		ce_i && eof_q != 2'b00 |=> irq_o)
		else $error("interrupt not raised");
	a_cal_len: assert property (
		ce_i && cal_go |=> cal_busy_q [*8])
		else $error("calibration ended early");
	a_empty_hold: assert property (
		ce_i && cnt_q[0] == 16'h0000 && !cal_go
		|=> $stable(dac_q[0]))
		else $error("empty channel changed output");
	a_wb_ack: assert property (
		ce_i && req |=> wb_ack_o)
		else $error("bus request not acknowledged");

	c_eof_out: cover property (eof_set[0]);
	c_burst: cover property (bst_q == ddos_pkg::ST_RUN
		##1 bst_q == ddos_pkg::ST_ARM);
	c_cal: cover property (cal_go);
	c_wrap: cover property (ctrl_q.circ && pop[0]
		&& nxt(rp_q[0], amask) == wp_q[0]);
endmodule
`default_nettype wire

// >>> inc/ddos_pkg.sv
// package: constants and types of the dual dac output sequencer
`default_nettype none
package ddos_pkg;
	// ==========================================
	// register byte offsets
	localparam logic [7:0] OFS_CTRL  = 8'h00;
	localparam logic [7:0] OFS_CMD   = 8'h04;
	localparam logic [7:0] OFS_RATE0 = 8'h08;
	localparam logic [7:0] OFS_RATE1 = 8'h0C;
	localparam logic [7:0] OFS_DIV0  = 8'h10;
	localparam logic [7:0] OFS_DIV1  = 8'h14;
	localparam logic [7:0] OFS_DATA0 = 8'h18;
	localparam logic [7:0] OFS_DATA1 = 8'h1C;
	localparam logic [7:0] OFS_STAT  = 8'h20;
	localparam logic [7:0] OFS_LEVEL = 8'h24;
	// ==========================================
	// command and status bit positions
	localparam int CMD_SWCLK = 0;
	localparam int CMD_TRIG  = 1;
	localparam int CMD_CAL   = 2;
	localparam int CMD_CLR   = 3;
	localparam int ST_EOF    = 4;
	// ==========================================
	// reset values and limits
	localparam logic [15:0] CTRL_RST  = 16'h0000;
	localparam logic [11:0] RATE_RST  = 12'h800;
	localparam logic [11:0] RATE_MIN  = 12'h51F;
	localparam logic [11:0] RATE_MAX  = 12'hA3D;
	localparam logic [15:0] DIV_RST   = 16'h003F;
	localparam logic [15:0] MIDSCALE  = 16'h8000;
	localparam logic [3:0]  DCODE_MAX = 4'hD;
	localparam logic [15:0] DEPTH_MIN = 16'h0004;
	localparam int          FDEPTH    = 32768;
	// ==========================================
	// timing
	localparam int CLK_HZ  = 50_000_000;
	localparam int MAX_SPS = 400_000;
	localparam int MIN_GAP = (CLK_HZ + MAX_SPS - 1) / MAX_SPS;
	localparam int CAL_MS  = 1500;
	localparam int CAL_CYC = (CLK_HZ / 1000) * CAL_MS;
	// ==========================================
	// types
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_ARM  = 2'b01,
		ST_RUN  = 2'b11
	} ddos_burst_t;
	typedef enum logic [1:0] {
		SRC_INT = 2'b00,
		SRC_EXT = 2'b01,
		SRC_SW  = 2'b10,
		SRC_OFF = 2'b11
	} ddos_src_t;
	typedef struct packed {
		logic [1:0] rsvd;
		logic [3:0] depth;
		ddos_src_t  src;
		logic       dma_en;
		logic       burst_en;
		logic       trig_out;
		logic       lvds;
		logic       simul;
		logic       circ;
		logic       twos;
		logic       sync_clk;
	} ddos_ctrl_t;
	typedef struct packed {
		logic        chan;
		logic [16:0] data;
	} ddos_dma_t;
endpackage
`default_nettype wire

// >>> verification/ddos_far_model.sv
// far side model: dma master and external sync source
`timescale 1ns/1ps
`default_nettype none
module ddos_far_model (
	input  wire logic           clk_i,
	input  wire logic           rst_i,
	input  wire logic [1:0]     dma_req_i,
	input  wire logic           dma_go_i,
	input  wire logic           ext_go_i,
	output logic                dma_valid_o,
	output ddos_pkg::ddos_dma_t dma_o,
	output logic                ttl_sync_o,
	output logic                lvds_sync_o
);
	logic [2:0] sent_q;
	logic [7:0] tick_q;
	// ==========================================
	// four words to channel 0, only while room is offered
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			sent_q      <= 3'h0;
			dma_valid_o <= 1'b0;
			dma_o       <= '0;
		end
		else if (dma_go_i && dma_req_i[0] && sent_q < 3'h4)
		begin
			dma_valid_o <= 1'b1;
			dma_o.chan  <= 1'b0;
			dma_o.data  <= {sent_q == 3'h3, 13'h0020, sent_q};
			sent_q      <= sent_q + 3'h1;
		end
		else
		begin
			dma_valid_o <= 1'b0;
			// idle data keeps moving so a stale word is never mistaken
			dma_o.data  <= ~dma_o.data;
		end
	end
	// ==========================================
	// one edge every 200 cycles stays below the 400k ceiling
	always_ff @(posedge clk_i)
	begin
		if (rst_i || !ext_go_i)
			tick_q <= 8'h00;
		else
			tick_q <= (tick_q == 8'hC7) ? 8'h00 : tick_q + 8'h01;
	end
	assign ttl_sync_o  = ext_go_i && (tick_q == 8'h10);
	assign lvds_sync_o = ext_go_i && (tick_q == 8'h10);
endmodule
`default_nettype wire

// >>> verification/ddos_top_tb_top.sv
// testbench: register and sample path checks of the sequencer
`timescale 1ns/1ps
`default_nettype none
module ddos_top_tb_top;
	localparam int CAL = 40;
	logic                clk_i;
	logic                rst_i;
	logic                cyc;
	logic                stb;
	logic                we;
	logic [7:0]          adr;
	logic [31:0]         wdat;
	logic [31:0]         rdat;
	logic                ack;
	logic                dvalid;
	ddos_pkg::ddos_dma_t dword;
	logic [1:0]          dreq;
	logic                ttl_in;
	logic                lvds_in;
	logic                ttl_out;
	logic                lvds_out;
	logic [15:0]         dac0;
	logic [15:0]         dac1;
	logic [1:0]          dac_ld;
	logic                cal_busy;
	logic                irq;
	logic                dma_go;
	logic                ext_go;
	logic [31:0]         rd;
	int                  miscompares;
	int                  tests_run;
	int                  cycles;
	int                  pulses;
	int                  lpulses;
	int                  lds;
	int                  n;
	// ==========================================
	// design and far side
	ddos_top #(.CAL_CYC(CAL)) dut (
		.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dma_valid_i(dvalid), .dma_i(dword), .dma_req_o(dreq),
		.ttl_sync_i(ttl_in), .lvds_sync_i(lvds_in), .ttl_sync_o(ttl_out),
		.lvds_sync_o(lvds_out), .dac0_o(dac0), .dac1_o(dac1),
		.dac_ld_o(dac_ld), .cal_busy_o(cal_busy), .irq_o(irq));
	ddos_far_model far (
		.clk_i(clk_i), .rst_i(rst_i), .dma_req_i(dreq), .dma_go_i(dma_go),
		.ext_go_i(ext_go), .dma_valid_o(dvalid), .dma_o(dword),
		.ttl_sync_o(ttl_in), .lvds_sync_o(lvds_in));
	// ==========================================
	// tasks
	task automatic check(input string what, input logic [31:0] seen,
		input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		@(posedge clk_i);
		cyc  <= 1'b1;
		stb  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		k = 0;
		do
		begin
			@(posedge clk_i);
			k++;
		end
		while (ack !== 1'b1 && k < 100);
		if (ack !== 1'b1)
			miscompares++;
		rd = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic idle(input int c);
		repeat (c) @(posedge clk_i);
	endtask
	task automatic tick();
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h1);
		idle(3);
	endtask
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ==========================================
	// clock, watchdog, sync pulse counters
	initial
	begin
		clk_i = 1'b0;
		forever #10 clk_i = ~clk_i;
	end
	always @(posedge clk_i)
	begin
		cycles++;
		if (ttl_out === 1'b1)
			pulses++;
		if (lvds_out === 1'b1)
			lpulses++;
		if (dac_ld === 2'b11)
			lds++;
		// the whole sequence needs a few thousand cycles
		if (cycles == 20000)
		begin
			miscompares++;
			final_report();
		end
	end
	// ==========================================
	// main sequence
	initial
	begin
		rst_i = 1'b1;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		dma_go = 1'b0;
		ext_go = 1'b0;
		miscompares = 0;
		tests_run = 0;
		cycles = 0;
		pulses = 0;
		lpulses = 0;
		lds = 0;
		idle(5);
		rst_i <= 1'b0;
		idle(2);
		check("dac0 reset", 32'(dac0), 32'h8000);
		check("dac1 reset", 32'(dac1), 32'h8000);
		check("ld idle", 32'(dac_ld), 32'h0);
		wb(1'b0, ddos_pkg::OFS_CTRL, 32'h0);
		check("ctrl reset", rd, 32'h0);
		wb(1'b0, ddos_pkg::OFS_DIV1, 32'h0);
		check("div1 reset", rd, 32'h3F);
		wb(1'b0, ddos_pkg::OFS_RATE0, 32'h0);
		check("rate0 reset", rd, 32'h800);
		wb(1'b0, 8'h30, 32'h0);
		check("unmapped", rd, 32'h0);
		wb(1'b1, ddos_pkg::OFS_DIV0, 32'hFFFF);
		wb(1'b0, ddos_pkg::OFS_DIV0, 32'h0);
		check("div0 16 bit", rd, 32'hFFFF);
		// a divisor below the running count would wrap all 16 bits
		wb(1'b1, ddos_pkg::OFS_DIV0, 32'hFF);
		wb(1'b1, ddos_pkg::OFS_RATE1, 32'h0);
		wb(1'b0, ddos_pkg::OFS_RATE1, 32'h0);
		check("rate low clamp", rd, 32'h51F);
		wb(1'b1, ddos_pkg::OFS_RATE1, 32'hFFF);
		wb(1'b0, ddos_pkg::OFS_RATE1, 32'h0);
		check("rate high clamp", rd, 32'hA3D);
		// software clock, simultaneous update, frame end flag
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h208);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h11234);
		wb(1'b1, ddos_pkg::OFS_DATA1, 32'h05678);
		lds = 0;
		tick();
		check("dac0 sw", 32'(dac0), 32'h1234);
		check("dac1 simul", 32'(dac1), 32'h5678);
		check("simul load", 32'(lds), 32'h1);
		check("irq eof", 32'(irq), 32'h1);
		wb(1'b0, ddos_pkg::OFS_STAT, 32'h0);
		check("eof flags", 32'(rd[5:4]), 32'h1);
		wb(1'b1, ddos_pkg::OFS_STAT, 32'h10);
		idle(3);
		check("irq cleared", 32'(irq), 32'h0);
		// empty open buffer keeps the last code
		idle(130);
		tick();
		check("dac0 hold", 32'(dac0), 32'h1234);
		// twos complement input, offset binary at converter
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h20A);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h0001);
		wb(1'b1, ddos_pkg::OFS_DATA1, 32'hFFFF);
		idle(130);
		tick();
		check("dac0 twos", 32'(dac0), 32'h8001);
		check("dac1 twos", 32'(dac1), 32'h7FFF);
		// circular replay wraps to the oldest entry
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h20C);
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h8);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'hAAAA);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h5555);
		for (int k = 0; k < 3; k++)
		begin
			idle(130);
			tick();
			check("dac0 circ", 32'(dac0),
				k == 1 ? 32'h5555 : 32'hAAAA);
		end
		// calibration runs a fixed count with outputs at midscale
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h4);
		idle(1);
		check("cal busy", 32'(cal_busy), 32'h1);
		check("cal dac0", 32'(dac0), 32'h8000);
		n = 0;
		while (cal_busy === 1'b1 && n < 200)
		begin
			idle(1);
			n++;
		end
		check("cal length", 32'(n >= CAL - 4 && n <= CAL), 32'h1);
		// external clock on ttl, then on lvds
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h108);
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h8);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h2222);
		pulses = 0;
		ext_go <= 1'b1;
		n = 0;
		while (dac0 !== 16'h2222 && n < 500)
		begin
			idle(1);
			n++;
		end
		// let the pulse counter see the sync pulse of that update
		idle(2);
		check("dac0 ext", 32'(dac0), 32'h2222);
		check("ttl out", 32'(pulses != 0), 32'h1);
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h118);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h3333);
		idle(5);
		pulses = 0;
		lpulses = 0;
		n = 0;
		while (dac0 !== 16'h3333 && n < 500)
		begin
			idle(1);
			n++;
		end
		idle(2);
		check("dac0 lvds", 32'(dac0), 32'h3333);
		check("lvds out", 32'(lpulses != 0), 32'h1);
		check("ttl quiet", 32'(pulses), 32'h0);
		ext_go <= 1'b0;
		// burst arms, software trigger runs it and goes out on sync
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h268);
		idle(2);
		wb(1'b0, ddos_pkg::OFS_STAT, 32'h0);
		check("burst armed", 32'(rd[8:7]), 32'h1);
		pulses = 0;
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h2);
		wb(1'b0, ddos_pkg::OFS_STAT, 32'h0);
		check("burst run", 32'(rd[8:7]), 32'h3);
		check("trig out", 32'(pulses), 32'h1);
		// dma fills channel 0 of a 16 deep buffer
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'hA88);
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h8);
		dma_go <= 1'b1;
		idle(130);
		wb(1'b0, ddos_pkg::OFS_LEVEL, 32'h0);
		check("dma level", 32'(rd[15:0]), 32'h4);
		check("dma req", 32'(dreq), 32'h3);
		tick();
		check("dma dac0", 32'(dac0), 32'h0100);
		// shared internal clock: channel 1 one cycle behind channel 0
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h301);
		wb(1'b1, ddos_pkg::OFS_CMD, 32'h8);
		wb(1'b1, ddos_pkg::OFS_DATA0, 32'h4444);
		wb(1'b1, ddos_pkg::OFS_DATA1, 32'h6666);
		// both gap counters must be idle before the clock is let in
		idle(130);
		wb(1'b1, ddos_pkg::OFS_CTRL, 32'h001);
		n = 0;
		while (dac0 !== 16'h4444 && n < 700)
		begin
			idle(1);
			n++;
		end
		check("seq dac0", 32'(dac0), 32'h4444);
		check("seq dac1 late", 32'(dac1 !== 16'h6666), 32'h1);
		idle(1);
		check("seq dac1", 32'(dac1), 32'h6666);
		final_report();
	end
endmodule
`default_nettype wire
